// [hdl/pwm_shutdown_pkg.sv]
// Purpose: shared constants for the dead-band and auto-shutdown stage
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: registers are eight bits wide, port direction four, upper bus bits read as zero
package pwm_shutdown_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] DEAD_BAND_RESTART_CONFIG_OFS = 8'h00;
  localparam logic [7:0] AUTO_SHUTDOWN_CONTROL_OFS = 8'h04;
  localparam logic [7:0] CAPTURE_COMPARE_CONTROL_OFS = 8'h08;
  localparam logic [7:0] DUTY_HIGH_BITS_OFS = 8'h0C;
  localparam logic [7:0] PERIOD_REGISTER_OFS = 8'h10;
  localparam logic [7:0] PERIOD_TIMER_CONTROL_OFS = 8'h14;
  localparam logic [7:0] PORT_DIRECTION_REG_OFS = 8'h18;
  localparam logic [7:0] BLOCK_STATUS_OFS = 8'h1C;

  // ==========================================================
  // reset values
  localparam logic [7:0] DEAD_BAND_RESTART_CONFIG_RST = 8'h00;
  localparam logic [7:0] AUTO_SHUTDOWN_CONTROL_RST = 8'h00;
  localparam logic [7:0] CAPTURE_COMPARE_CONTROL_RST = 8'h00;
  localparam logic [7:0] DUTY_HIGH_BITS_RST = 8'h00;
  localparam logic [7:0] PERIOD_REGISTER_RST = 8'hFF;
  localparam logic [7:0] PERIOD_TIMER_CONTROL_RST = 8'h00;
  localparam logic [3:0] PORT_DIRECTION_REG_RST = 4'hF;

  // ==========================================================
  // field positions
  localparam int AUTO_RESTART_ENABLE_BIT = 7;
  localparam int SHUTDOWN_STATUS_BIT = 7;
  localparam int SRC_PIN_ZERO_BIT = 6;
  localparam int SRC_PIN_TWO_BIT = 5;
  localparam int SRC_PIN_ONE_BIT = 4;
  localparam int PAIR_AC_LEVEL_LSB = 2;
  localparam int PAIR_BD_LEVEL_LSB = 0;
  localparam int POLARITY_AC_BIT = 1;
  localparam int POLARITY_BD_BIT = 0;
  localparam int DUTY_LOW_LSB = 4;
  localparam int OUTPUT_CONFIG_LSB = 6;
  localparam int TIMER_RUN_BIT = 0;
  localparam int TIMER_PRESCALE_LSB = 1;
  localparam int TIMER_FLAG_BIT = 7;

  // ==========================================================
  // timing: one oscillator period is one hclk
  localparam int OSC_PER_INSTRUCTION = 4;
  localparam logic [1:0] INSTR_LAST_PHASE = 2'h3;
  localparam logic [3:0] PRESCALE_1_LAST = 4'h0;
  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ==========================================================
  // output configurations
  typedef enum logic [1:0] {
    CFG_SINGLE,
    CFG_FULL_FORWARD,
    CFG_HALF_BRIDGE,
    CFG_FULL_REVERSE
  } output_config_e;

endpackage

// [hdl/pwm_deadband_autoshutdown.sv]
// Purpose: dead-band delay and auto-shutdown for a four-pin PWM stage
// Assumes: hclk is the oscillator, an instruction cycle is 4 clocks
// Notes: shutdown pins pass a two-flop synchroniser before use
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module pwm_deadband_autoshutdown (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_irq_pin_zero,
  input wire logic ext_irq_pin_one,
  input wire logic ext_irq_pin_two,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output logic pwm_oe_n_a,
  output logic pwm_oe_n_b,
  output logic pwm_oe_n_c,
  output logic pwm_oe_n_d
);
  import pwm_shutdown_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [7:0] dead_band_restart_config;
    logic [7:0] auto_shutdown_control;
    logic [7:0] capture_compare_control;
    logic [7:0] duty_high_bits;
    logic [7:0] period_register;
    logic [7:0] period_timer_control;
    logic [3:0] port_direction_reg;
    logic hw_cause;
    logic shut_active;
    logic [3:0] prescale_cnt;
    logic [1:0] osc_phase;
    logic [1:0] instr_div;
    logic [7:0] period_timer_count;
    logic [9:0] duty_latched;
    logic [6:0] dead_a;
    logic [6:0] dead_b;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] pin_level;
    logic [3:0] pin_oe_n;
  } state_s;

  state_s s;
  state_s next_s;

  // ==========================================================
  // combinational helpers
  logic [2:0] pin_low;
  logic shutdown_cause;
  logic instr_en;
  logic osc_tick;
  logic period_start;
  logic [3:0] prescale_last;
  logic pwm_raw;
  logic [3:0] target;
  logic [3:0] active;
  logic half_bridge;
  logic shut_now;
  logic [1:0] lvl;
  logic pol_low;
  output_config_e cfg;
  logic addr_phase;
  logic [7:0] rd_addr;
  logic [7:0] rd_byte;
  logic status_written;

  always_comb begin
    next_s = s;
    pin_low = '0;
    shutdown_cause = 1'b0;
    instr_en = 1'b0;
    osc_tick = 1'b0;
    period_start = 1'b0;
    prescale_last = PRESCALE_1_LAST;
    pwm_raw = 1'b0;
    target = '0;
    active = '0;
    half_bridge = 1'b0;
    shut_now = 1'b0;
    lvl = '0;
    pol_low = 1'b0;
    cfg = CFG_SINGLE;
    addr_phase = 1'b0;
    rd_addr = '0;
    rd_byte = '0;
    status_written = 1'b0;

    // ========================================================
    // pin synchronisers: only the second stage is read
    next_s.pin_meta = {ext_irq_pin_two, ext_irq_pin_one, ext_irq_pin_zero};
    next_s.pin_sync = s.pin_meta;
    pin_low = ~s.pin_sync;
    // level-sensitive so the cause is re-seen every cycle
    shutdown_cause =
      (s.auto_shutdown_control[SRC_PIN_ZERO_BIT] & pin_low[0]) |
      (s.auto_shutdown_control[SRC_PIN_TWO_BIT] & pin_low[2]) |
      (s.auto_shutdown_control[SRC_PIN_ONE_BIT] & pin_low[1]);

    // ========================================================
    // register writes (data phase of the previous transfer)
    if (s.wr_pend) begin
      case (s.wr_addr)
        DEAD_BAND_RESTART_CONFIG_OFS: begin
          next_s.dead_band_restart_config = hwdata[7:0];
        end
        AUTO_SHUTDOWN_CONTROL_OFS: begin
          next_s.auto_shutdown_control[6:0] = hwdata[6:0];
          if (!shutdown_cause) begin
            next_s.auto_shutdown_control[SHUTDOWN_STATUS_BIT] =
              hwdata[SHUTDOWN_STATUS_BIT];
            next_s.hw_cause = 1'b0;
            status_written = 1'b1;
          end
        end
        CAPTURE_COMPARE_CONTROL_OFS: begin
          next_s.capture_compare_control = hwdata[7:0];
        end
        DUTY_HIGH_BITS_OFS: begin
          next_s.duty_high_bits = hwdata[7:0];
        end
        PERIOD_REGISTER_OFS: begin
          next_s.period_register = hwdata[7:0];
        end
        PERIOD_TIMER_CONTROL_OFS: begin
          next_s.period_timer_control = hwdata[7:0];
        end
        PORT_DIRECTION_REG_OFS: begin
          next_s.port_direction_reg = hwdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // ========================================================
    // shutdown status: a live cause always wins over any clear
    if (shutdown_cause) begin
      next_s.auto_shutdown_control[SHUTDOWN_STATUS_BIT] = 1'b1;
      next_s.hw_cause = 1'b1;
    end else if (!status_written && s.hw_cause &&
                 s.dead_band_restart_config[AUTO_RESTART_ENABLE_BIT]) begin
      // a forced shutdown has no cause, so it never auto-clears
      next_s.auto_shutdown_control[SHUTDOWN_STATUS_BIT] = 1'b0;
      next_s.hw_cause = 1'b0;
    end

    // ========================================================
    // instruction-cycle enable and period timer
    next_s.instr_div = s.instr_div + 2'h1;
    instr_en = (s.instr_div == INSTR_LAST_PHASE);
    case (s.period_timer_control[TIMER_PRESCALE_LSB +: 2])
      2'h0: prescale_last = PRESCALE_1_LAST;
      2'h1: prescale_last = PRESCALE_4_LAST;
      default: prescale_last = PRESCALE_16_LAST;
    endcase
    if (s.period_timer_control[TIMER_RUN_BIT]) begin
      if (s.prescale_cnt >= prescale_last) begin
        next_s.prescale_cnt = '0;
        osc_tick = 1'b1;
      end else begin
        next_s.prescale_cnt = s.prescale_cnt + 4'h1;
      end
    end
    if (osc_tick) begin
      next_s.osc_phase = s.osc_phase + 2'h1;
      if (s.osc_phase == INSTR_LAST_PHASE) begin
        if (s.period_timer_count == s.period_register) begin
          next_s.period_timer_count = '0;
          period_start = 1'b1;
        end else begin
          next_s.period_timer_count = s.period_timer_count + 8'h01;
        end
      end
    end
    if (period_start) begin
      next_s.duty_latched = {s.duty_high_bits,
        s.capture_compare_control[DUTY_LOW_LSB +: 2]};
      next_s.period_timer_control[TIMER_FLAG_BIT] = 1'b1;
    end

    // ========================================================
    // raw waveform and output configuration
    // duty above the period never clears the waveform
    pwm_raw = ({s.period_timer_count, s.osc_phase} < s.duty_latched);
    cfg = output_config_e'(
      s.capture_compare_control[OUTPUT_CONFIG_LSB +: 2]);
    case (cfg)
      CFG_SINGLE: target = {3'b000, pwm_raw};
      CFG_FULL_FORWARD: target = {pwm_raw, 2'b00, 1'b1};
      CFG_HALF_BRIDGE: target = {2'b00, ~pwm_raw, pwm_raw};
      CFG_FULL_REVERSE: target = {1'b0, 1'b1, pwm_raw, 1'b0};
      default: target = '0;
    endcase
    half_bridge = (cfg == CFG_HALF_BRIDGE);

    // ========================================================
    // dead band: counter reloads while inactive, runs after rising
    if (!target[0]) begin
      next_s.dead_a = half_bridge ?
        s.dead_band_restart_config[6:0] : 7'h00;
    end else if (instr_en && (s.dead_a != 7'h00)) begin
      next_s.dead_a = s.dead_a - 7'h01;
    end
    if (!target[1]) begin
      next_s.dead_b = half_bridge ?
        s.dead_band_restart_config[6:0] : 7'h00;
    end else if (instr_en && (s.dead_b != 7'h00)) begin
      next_s.dead_b = s.dead_b - 7'h01;
    end
    // falling edges pass at once; in half-bridge mode a pulse shorter than the dead band never gets through
    active = target;
    active[0] = target[0] & (s.dead_a == 7'h00);
    active[1] = target[1] & (s.dead_b == 7'h00);

    // ========================================================
    // shutdown hold across the period
    if (s.auto_shutdown_control[SHUTDOWN_STATUS_BIT]) begin
      next_s.shut_active = 1'b1;
    end else if (period_start) begin
      next_s.shut_active = 1'b0;
    end
    shut_now = s.shut_active |
      s.auto_shutdown_control[SHUTDOWN_STATUS_BIT] |
      shutdown_cause;

    // ========================================================
    // pin drive: a=0 b=1 c=2 d=3, pairs a/c and b/d
    for (int i = 0; i < 4; i++) begin
      if (i == 0 || i == 2) begin
        lvl = s.auto_shutdown_control[PAIR_AC_LEVEL_LSB +: 2];
        pol_low = s.capture_compare_control[POLARITY_AC_BIT];
      end else begin
        lvl = s.auto_shutdown_control[PAIR_BD_LEVEL_LSB +: 2];
        pol_low = s.capture_compare_control[POLARITY_BD_BIT];
      end
      if (shut_now) begin
        next_s.pin_level[i] = lvl[0];
        next_s.pin_oe_n[i] = lvl[1] | s.port_direction_reg[i];
      end else begin
        next_s.pin_level[i] = active[i] ^ pol_low;
        next_s.pin_oe_n[i] = s.port_direction_reg[i];
      end
    end

    // ========================================================
    // AHB-Lite slave, zero wait states, always OKAY
    addr_phase = hsel & hready & htrans[1];
    // writes outside the decoded page are dropped, as reads return zero
    next_s.wr_pend = addr_phase & hwrite & (hsize == HSIZE_WORD) &
      (haddr[31:8] == 24'h000000);
    next_s.wr_addr = haddr[7:0];
    rd_addr = haddr[7:0];
    if (haddr[31:8] != 24'h000000) begin
      rd_addr = 8'hFF;
    end
    // read from next values so a write just before is seen
    case (rd_addr)
      DEAD_BAND_RESTART_CONFIG_OFS: rd_byte = next_s.dead_band_restart_config;
      AUTO_SHUTDOWN_CONTROL_OFS: rd_byte = next_s.auto_shutdown_control;
      CAPTURE_COMPARE_CONTROL_OFS: rd_byte = next_s.capture_compare_control;
      DUTY_HIGH_BITS_OFS: rd_byte = next_s.duty_high_bits;
      PERIOD_REGISTER_OFS: rd_byte = next_s.period_register;
      PERIOD_TIMER_CONTROL_OFS: rd_byte = next_s.period_timer_control;
      PORT_DIRECTION_REG_OFS: rd_byte = {4'h0, next_s.port_direction_reg};
      BLOCK_STATUS_OFS: rd_byte = {2'b00, s.shut_active, shutdown_cause,
        pin_low[2], pin_low[1], pin_low[0], pwm_raw};
      default: rd_byte = 8'h00;
    endcase
    if (addr_phase && !hwrite) begin
      next_s.hrdata = {24'h000000, rd_byte};
    end
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.dead_band_restart_config <= DEAD_BAND_RESTART_CONFIG_RST;
      s.auto_shutdown_control <= AUTO_SHUTDOWN_CONTROL_RST;
      s.capture_compare_control <= CAPTURE_COMPARE_CONTROL_RST;
      s.duty_high_bits <= DUTY_HIGH_BITS_RST;
      s.period_register <= PERIOD_REGISTER_RST;
      s.period_timer_control <= PERIOD_TIMER_CONTROL_RST;
      s.port_direction_reg <= PORT_DIRECTION_REG_RST;
      s.pin_oe_n <= 4'hF;
      s.pin_meta <= 3'h7;
      s.pin_sync <= 3'h7;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign pwm_out_a = s.pin_level[0];
  assign pwm_out_b = s.pin_level[1];
  assign pwm_out_c = s.pin_level[2];
  assign pwm_out_d = s.pin_level[3];
  assign pwm_oe_n_a = s.pin_oe_n[0];
  assign pwm_oe_n_b = s.pin_oe_n[1];
  assign pwm_oe_n_c = s.pin_oe_n[2];
  assign pwm_oe_n_d = s.pin_oe_n[3];

endmodule

// [testbench/pwm_shutdown_properties.sv]
// Purpose: port properties of the dead-band and shutdown stage
// Assumes: word writes only, registers in bits 7:0
// Notes: shadows follow control and direction writes on the bus
`timescale 1ns/1ps
module pwm_shutdown_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ext_irq_pin_zero,
  input wire logic ext_irq_pin_one,
  input wire logic ext_irq_pin_two,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic pwm_out_c,
  input wire logic pwm_out_d,
  input wire logic pwm_oe_n_a,
  input wire logic pwm_oe_n_b,
  input wire logic pwm_oe_n_c,
  input wire logic pwm_oe_n_d
);
  import pwm_shutdown_pkg::*;
  // ==========================================================
  // shadows; levels only judged once config and cause settle
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] ctl;
  logic [3:0] dir;
  logic [7:0] ofs;
  logic wr;
  logic rd04;
  logic [2:0] cnt;
  logic [2:0] age;
  logic take;
  logic wctl;
  logic cause;
  logic hold;
  logic ac_ok;
  logic bd_ok;
  logic [3:0] oe;
  assign take = hsel && hready && htrans[1];
  assign wctl = wr && ofs == AUTO_SHUTDOWN_CONTROL_OFS;
  assign cause = |(ctl[6:4] &
    ~{ext_irq_pin_zero, ext_irq_pin_two, ext_irq_pin_one});
  assign hold = cnt >= 3'h5 && age >= 3'h3;
  assign oe = {pwm_oe_n_d, pwm_oe_n_c, pwm_oe_n_b, pwm_oe_n_a};
  assign ac_ok = ctl[3] ? pwm_oe_n_a && pwm_oe_n_c :
    (pwm_oe_n_a || pwm_out_a == ctl[2]) && (pwm_oe_n_c || pwm_out_c == ctl[2]);
  assign bd_ok = ctl[1] ? pwm_oe_n_b && pwm_oe_n_d :
    (pwm_oe_n_b || pwm_out_b == ctl[0]) && (pwm_oe_n_d || pwm_out_d == ctl[0]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl <= 8'h00;
      dir <= 4'hF;
      ofs <= 8'h00;
      wr <= 1'h0;
      rd04 <= 1'h0;
      cnt <= 3'h0;
      age <= 3'h0;
    end else begin
      wr <= take && hwrite;
      rd04 <= take && !hwrite && haddr[7:0] == AUTO_SHUTDOWN_CONTROL_OFS;
      if (take) begin
        ofs <= haddr[7:0];
      end
      if (wctl) begin
        ctl <= hwdata[7:0];
      end
      if (wr && ofs == PORT_DIRECTION_REG_OFS) begin
        dir <= hwdata[3:0];
      end
      age <= wctl ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
      cnt <= !cause ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
    end
  end
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  rdata_hold_a: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
    else $error("read data changed without a read");
  reset_release_a: assert property (!$past(hresetn) |-> oe == 4'hF)
    else $error("pins driven right after reset");
  dir_release_a: assert property ((dir & $past(dir) & ~oe) == 4'h0)
    else $error("pin driven while set as input");
  shutdown_ac_a: assert property (hold |-> ac_ok)
    else $error("pair a c not at shutdown level");
  shutdown_bd_a: assert property (hold |-> bd_ok)
    else $error("pair b d not at shutdown level");
  status_read_a: assert property (rd04 && hold |-> hrdata[7])
    else $error("status bit low during shutdown cause");
  cover property (hold && !ctl[3]);
  cover property (rd04 && hrdata[7]);
  cover property ($rose(pwm_out_a) && !pwm_oe_n_a);
endmodule
bind pwm_deadband_autoshutdown pwm_shutdown_properties chk_u (.*);

// [testbench/bridge_driver_model.sv]
// Purpose: bridge switch drivers on the four pwm pins
// Assumes: external pull-downs hold released pins low
// Notes: fault_req stands for an overcurrent trip on the sense line
`timescale 1ns/1ps
module bridge_driver_model (
  input wire logic [3:0] level,
  input wire logic [3:0] oe_n,
  input wire logic fault_req,
  output logic [3:0] pad,
  output logic fault_n,
  output logic shoot
);
  // ==========================================================
  // released pins fall low, so the switches stay off
  assign pad = level & ~oe_n;
  assign fault_n = !fault_req;
  // upper and lower switch of the half bridge on together
  assign shoot = pad[0] && pad[1];
endmodule

// [testbench/pwm_deadband_autoshutdown_tb_top.sv]
// Purpose: register-level tests of the dead-band and shutdown stage
// Assumes: hclk 250 MHz, single word AHB-Lite transfers
// Notes: pads seen through the bridge model, released pins read low
`timescale 1ns/1ps
module pwm_deadband_autoshutdown_tb_top;
  import pwm_shutdown_pkg::*;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic irq_one = 1'h1;
  logic irq_two = 1'h1;
  logic fault_req = 1'h0;
  logic fault_n;
  logic shoot;
  logic [3:0] outs;
  logic [3:0] oe;
  logic [3:0] pad;
  int failures = 0;
  int samples_checked = 0;
  always #2 hclk = ~hclk;
  pwm_deadband_autoshutdown dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .ext_irq_pin_zero(fault_n), .ext_irq_pin_one(irq_one),
    .ext_irq_pin_two(irq_two), .pwm_out_a(outs[0]), .pwm_out_b(outs[1]),
    .pwm_out_c(outs[2]), .pwm_out_d(outs[3]), .pwm_oe_n_a(oe[0]),
    .pwm_oe_n_b(oe[1]), .pwm_oe_n_c(oe[2]), .pwm_oe_n_d(oe[3]));
  bridge_driver_model bridge_u (.level(outs), .oe_n(oe),
    .fault_req(fault_req), .pad(pad), .fault_n(fault_n), .shoot(shoot));
  // ==========================================================
  // bus and compare tasks
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, {24'h0, d}, q);
  endtask
  task automatic rd(input string what, input logic [7:0] a,
    input logic [7:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    check(what, q, {24'h0, exp});
  endtask
  task automatic pins(input logic [2:0] low);
    fault_req <= low[0];
    irq_one <= !low[1];
    irq_two <= !low[2];
  endtask
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask
  // counts over 64 cycles; sampled away from the launching edge
  task automatic watch(output int na, output int nb, output int nc,
    output int nd, output int ns);
    na = 0;
    nb = 0;
    nc = 0;
    nd = 0;
    ns = 0;
    repeat (64) begin
      @(negedge hclk);
      na += pad[0];
      nb += pad[1];
      nc += pad[2];
      nd += pad[3];
      ns += shoot;
    end
    @(posedge hclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    print_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    int na;
    int nb;
    int ns;
    int nc;
    int nd;
    logic [31:0] q;
    logic [7:0] md [3];
    logic [31:0] ex [3];
    logic [7:0] ofs_t [8];
    logic [7:0] rst_t [8];
    logic [7:0] sel [3];
    logic [1:0] ac [4];
    logic [1:0] bd [4];
    logic [3:0] eo;
    logic [3:0] ez;
    ofs_t = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
    rst_t = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00};
    sel = '{8'h40, 8'h10, 8'h20};
    ac = '{2'h0, 2'h1, 2'h2, 2'h1};
    bd = '{2'h1, 2'h0, 2'h1, 2'h3};
    // single, full forward, full reverse; counts of a b c d in 64 clocks
    md = '{8'h00, 8'h40, 8'hC0};
    ex = '{32'h20000000, 32'h40000020, 32'h00204000};
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    check("oe_n after reset", {28'h0, oe}, 32'hF);
    check("pads after reset", {28'h0, pad}, 32'h0);
    wr(8'h20, 8'hFF);
    for (int i = 0; i < 8; i++) rd("reset value", ofs_t[i], rst_t[i]);
    wr(8'h00, 8'hFF);
    rd("dead band config", 8'h00, 8'hFF);
    wr(8'h00, 8'h00);
    $display("test registers done");
    wr(8'h18, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, {4'h8, ac[i], bd[i]});
      settle();
      eo = {bd[i][0], ac[i][0], bd[i][0], ac[i][0]};
      ez = {bd[i][1], ac[i][1], bd[i][1], ac[i][1]};
      check("release", {28'h0, oe}, {28'h0, ez});
      check("level", {28'h0, pad}, {28'h0, eo & ~ez});
      rd("forced status", 8'h04, {4'h8, ac[i], bd[i]});
    end
    wr(8'h04, 8'h00);
    rd("status cleared", 8'h04, 8'h00);
    $display("test forced shutdown done");
    wr(8'h00, 8'h80);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, sel[i]);
      pins(3'h1 << i);
      settle();
      rd("pin shutdown", 8'h04, sel[i] | 8'h80);
      wr(8'h04, sel[i]);
      rd("clear refused", 8'h04, sel[i] | 8'h80);
      pins(3'h0);
      settle();
      rd("auto restart", 8'h04, sel[i]);
    end
    wr(8'h04, 8'h00);
    pins(3'h7);
    settle();
    rd("no source", 8'h04, 8'h00);
    pins(3'h1);
    wr(8'h04, 8'h30);
    settle();
    rd("pin unselected", 8'h04, 8'h30);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h40);
    settle();
    pins(3'h0);
    settle();
    rd("latched status", 8'h04, 8'hC0);
    wr(8'h04, 8'h00);
    rd("software clear", 8'h04, 8'h00);
    $display("test shutdown sources done");
    wr(8'h18, 8'h0F);
    wr(8'h10, 8'h03);
    wr(8'h0C, 8'h02);
    wr(8'h14, 8'h01);
    repeat (40) @(posedge hclk);
    rd("period flag", 8'h14, 8'h81);
    wr(8'h14, 8'h01);
    for (int p = 0; p < 2; p++) begin
      wr(8'h18, 8'h0F);
      wr(8'h08, {6'h20, p[0], 1'h0});
      wr(8'h00, 8'h7F);
      wr(8'h18, 8'h00);
      repeat (40) @(posedge hclk);
      watch(na, nb, nc, nd, ns);
      check("a held inactive", 32'(na), 32'(64 * p));
      check("b held inactive", 32'(nb), 32'h0);
    end
    wr(8'h18, 8'h0F);
    wr(8'h08, 8'h80);
    wr(8'h00, 8'h01);
    wr(8'h18, 8'h00);
    repeat (40) @(posedge hclk);
    watch(na, nb, nc, nd, ns);
    check("both switch", {31'h0, na > 0 && nb > 0}, 32'h1);
    check("no overlap", 32'(ns), 32'h0);
    $display("test dead band done");
    for (int m = 0; m < 3; m++) begin
      wr(8'h18, 8'h0F);
      wr(8'h08, md[m]);
      wr(8'h18, 8'h00);
      repeat (40) @(posedge hclk);
      watch(na, nb, nc, nd, ns);
      check("mode pads", {na[7:0], nb[7:0], nc[7:0], nd[7:0]}, ex[m]);
    end
    $display("test output modes done");
    // sync to a period start, then clear the status inside that period
    wr(8'h04, 8'h80);
    wr(8'h14, 8'h01);
    q = '0;
    while (!q[7]) bus(1'h0, 8'h14, 32'h0, q);
    wr(8'h04, 8'h00);
    check("pads held", {28'h0, pad}, 32'h0);
    bus(1'h0, 8'h1C, 32'h0, q);
    check("hold flag", q & 32'h20, 32'h20);
    repeat (20) @(posedge hclk);
    check("pad c resumed", {31'h0, pad[2]}, 32'h1);
    bus(1'h0, 8'h1C, 32'h0, q);
    check("hold ended", q & 32'h20, 32'h0);
    $display("test period hold done");
    print_verdict();
  end
endmodule
